// ===== hdl/csd_pkg.sv
// Package: register map, fields, codes and timing of the change detector
package csd_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_MEM_ADDR = 8'h00;
  localparam logic [7:0] A_MEM_DATA = 8'h04;
  localparam logic [7:0] A_MEM_CMD = 8'h08;
  localparam logic [7:0] A_TIMER = 8'h0c;
  localparam logic [7:0] A_CMD = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_IRQ_SRC = 8'h18;
  localparam logic [7:0] A_IRQ_MASK = 8'h1c;
  localparam logic [7:0] A_QUEUE = 8'h20;
  localparam logic [7:0] A_MODE = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_SSR = 7;
  localparam int B_ST = 6;
  localparam int B_CFR = 4;
  localparam int B_SFI = 6;
  localparam int B_TAC = 3;
  localparam int B_MAC = 7;
  localparam int B_RWS = 7;
  localparam int B_OPERATING_MODE_BIT0 = 0;
  localparam int B_DIR = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TIMER = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h05;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;

  // ----------------------------------------------------------------
  // Memory operation and channel codes
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_CODE_WR = 3'h7;
  localparam logic [3:0] OP_DATA = 4'h9;
  localparam logic [3:0] CODE_CI = 4'h7;
  localparam logic [3:0] CODE_SIG6 = 4'ha;
  localparam logic [3:0] CODE_SIG8 = 4'hb;
  localparam logic [7:0] MSK_CI = 8'h3c;
  localparam logic [7:0] MSK_SIG6 = 8'hfc;
  localparam logic [7:0] MSK_SIG8 = 8'hff;

  // ----------------------------------------------------------------
  // Queue and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] Q_DEPTH = 4'h9;
  localparam int FRAME_US = 125;
  localparam int TICK_US = 250;
  localparam int CLK_MHZ = 100;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;

endpackage : csd_pkg

// ===== hdl/csd_top.sv
// Control/signaling change detector with AHB-Lite register slave
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps

module csd_top #(
  parameter int TICK_CYCLES = csd_pkg::TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic frame_sync,
  input wire logic up_valid,
  input wire logic [6:0] up_slot,
  input wire logic [7:0] up_value,
  output logic up_ready,
  input wire logic [6:0] ds_slot,
  output logic [7:0] ds_data,
  output logic timer_tick,
  output logic irq_pin_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] cm_data [0:255];
  logic [3:0] cm_code [0:255];
  logic [7:0] queue [0:8];
  logic [3:0] q_rd_ff, q_wr_ff, q_cnt_ff, nxt_q_cnt;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] hrdata_ff;
  logic [7:0] mem_addr_ff, mem_data_ff, mem_cmd_ff;
  logic mem_busy_ff;
  logic [7:0] timer_set_ff, mode_ff, mask_ff;
  logic run_ff;
  logic [14:0] pre_ff;
  logic [6:0] unit_ff;
  logic due_ff, window_ff;
  logic [7:0] ds_data_ff;
  logic acc, rd_acc, mapped, rd_q, pop;
  logic [7:0] wd;
  logic wr_timer, wr_cmd, wr_mode, wr_mdata, wr_mcmd;
  logic tick;
  logic [7:0] even_a, odd_a, msk, v, act, stab;
  logic [3:0] code_e;
  logic is_ci, is_sup, sup_go, ci_chg, sup_chg, need_q, q_full;
  logic up_take, push, clr, exec;
  logic [7:0] push_addr;
  logic [7:0] ds_a;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign acc = ce & hsel & htrans[1] & hready;
  assign rd_acc = acc & ~hwrite;
  assign mapped = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'b00);
  assign rd_q = rd_acc & mapped & (haddr[7:0] == csd_pkg::A_QUEUE);
  assign pop = rd_q & (q_cnt_ff != 4'h0);
  assign wd = hwdata[7:0];
  assign wr_timer = ce & wr_pend_ff & (wr_addr_ff == csd_pkg::A_TIMER);
  assign wr_cmd = ce & wr_pend_ff & (wr_addr_ff == csd_pkg::A_CMD);
  assign wr_mode = ce & wr_pend_ff & (wr_addr_ff == csd_pkg::A_MODE);
  assign wr_mdata = ce & wr_pend_ff & (wr_addr_ff == csd_pkg::A_MEM_DATA);
  assign wr_mcmd = ce & wr_pend_ff & (wr_addr_ff == csd_pkg::A_MEM_CMD);
  assign clr = wr_cmd & wd[csd_pkg::B_CFR];

  // Zero-wait slave: every transfer completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, hrdata_ff};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (ce && hready) begin
      wr_pend_ff <= acc & hwrite & mapped;
      wr_addr_ff <= haddr[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data, latched in the address phase
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata_ff <= 8'h00;
    end else if (rd_acc) begin
      hrdata_ff <= 8'h00;
      if (mapped) begin
        unique case (haddr[7:0])
          csd_pkg::A_MEM_ADDR: hrdata_ff <= mem_addr_ff;
          csd_pkg::A_MEM_DATA: hrdata_ff <= mem_data_ff;
          csd_pkg::A_MEM_CMD: hrdata_ff <= mem_cmd_ff;
          csd_pkg::A_STATUS: begin
            hrdata_ff <= csd_pkg::RST_STATUS;
            hrdata_ff[csd_pkg::B_TAC] <= run_ff;
            hrdata_ff[csd_pkg::B_MAC] <= mem_busy_ff;
          end
          csd_pkg::A_IRQ_SRC: begin
            hrdata_ff[csd_pkg::B_SFI] <= q_cnt_ff != 4'h0;
          end
          csd_pkg::A_IRQ_MASK: hrdata_ff <= mask_ff;
          csd_pkg::A_QUEUE: begin
            // Empty queue answers with the valid bit low
            if (q_cnt_ff != 4'h0) begin
              hrdata_ff <= queue[q_rd_ff];
            end
          end
          csd_pkg::A_MODE: hrdata_ff <= mode_ff;
          default: hrdata_ff <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_set_ff <= csd_pkg::RST_TIMER;
      mode_ff <= csd_pkg::RST_MODE;
      mask_ff <= csd_pkg::RST_IRQ_MASK;
      mem_addr_ff <= 8'h00;
      mem_cmd_ff <= 8'h00;
    end else if (ce && wr_pend_ff) begin
      if (wr_addr_ff == csd_pkg::A_TIMER) begin
        timer_set_ff <= wd;
      end
      if (wr_addr_ff == csd_pkg::A_MODE) begin
        mode_ff <= wd;
      end
      if (wr_addr_ff == csd_pkg::A_IRQ_MASK) begin
        mask_ff <= wd;
      end
      if (wr_addr_ff == csd_pkg::A_MEM_ADDR) begin
        mem_addr_ff <= wd;
      end
      if (wr_mcmd) begin
        mem_cmd_ff <= wd;
      end
    end
  end

  // Data register is also the target of a memory read operation
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_data_ff <= 8'h00;
    end else if (ce) begin
      if (exec && mem_cmd_ff[csd_pkg::B_RWS]) begin
        mem_data_ff <= cm_data[mem_addr_ff];
      end else if (wr_mdata) begin
        mem_data_ff <= wd;
      end
    end
  end

  // Busy holds an operation until the upstream side leaves memory free
  assign exec = mem_busy_ff & ~up_take;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_busy_ff <= 1'b0;
    end else if (ce) begin
      if (wr_mcmd) begin
        mem_busy_ff <= 1'b1;
      end else if (exec) begin
        mem_busy_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer
  // ----------------------------------------------------------------
  assign tick = run_ff & (pre_ff == 15'(TICK_CYCLES - 1)) &
                (unit_ff == timer_set_ff[6:0]);
  assign timer_tick = tick;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_ff <= 1'b0;
    end else if (ce) begin
      if (wr_timer || !mode_ff[csd_pkg::B_OPERATING_MODE_BIT0]) begin
        run_ff <= 1'b0;
      end else if (wr_cmd && wd[csd_pkg::B_ST]) begin
        run_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_ff <= 15'h0000;
      unit_ff <= 7'h00;
    end else if (ce) begin
      if (!run_ff) begin
        pre_ff <= 15'h0000;
        unit_ff <= 7'h00;
      end else if (pre_ff == 15'(TICK_CYCLES - 1)) begin
        pre_ff <= 15'h0000;
        unit_ff <= tick ? 7'h00 : unit_ff + 7'h01;
      end else begin
        pre_ff <= pre_ff + 15'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Last-look window: opened for one whole frame per period, or for every frame while SSR is set
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      due_ff <= 1'b0;
      window_ff <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        due_ff <= 1'b1; // A tick in the frame edge cycle is kept
      end else if (frame_sync) begin
        due_ff <= 1'b0;
      end
      if (frame_sync) begin
        window_ff <= timer_set_ff[csd_pkg::B_SSR] | due_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Upstream change detection
  // ----------------------------------------------------------------
  assign even_a = {1'b1, up_slot[6:1], 1'b0};
  assign odd_a = {1'b1, up_slot[6:1], 1'b1};
  assign code_e = cm_code[even_a];
  assign act = cm_data[even_a];
  assign stab = cm_data[odd_a];
  assign is_ci = code_e == csd_pkg::CODE_CI;
  assign is_sup = (code_e == csd_pkg::CODE_SIG6) |
                  (code_e == csd_pkg::CODE_SIG8);
  assign msk = is_ci ? csd_pkg::MSK_CI :
               (code_e == csd_pkg::CODE_SIG6) ? csd_pkg::MSK_SIG6 :
               csd_pkg::MSK_SIG8;
  assign v = up_value & msk;
  assign ci_chg = is_ci & (v != act);
  assign sup_go = is_sup & window_ff;
  assign sup_chg = sup_go & (v == act) & (v != stab);
  assign need_q = ci_chg | sup_chg;
  assign q_full = q_cnt_ff == csd_pkg::Q_DEPTH;
  // Held off rather than dropped, so the source retries the change
  // Only an offered change stalls; an idle bus never shows a stall
  assign up_ready = ~(up_valid & need_q & q_full);
  assign up_take = ce & up_valid & up_ready & mode_ff[csd_pkg::B_OPERATING_MODE_BIT0];
  assign push = up_take & need_q;
  assign push_addr = ci_chg ? even_a : odd_a;

  always_ff @(posedge ref_clk) begin
    if (ce) begin
      if (up_take && (ci_chg || sup_go)) begin
        cm_data[even_a] <= v;
        if (sup_chg) begin
          cm_data[odd_a] <= v;
        end
      end else if (exec && !mem_cmd_ff[csd_pkg::B_RWS]) begin
        if (mem_cmd_ff[6:4] == csd_pkg::OP_CODE_WR) begin
          cm_code[mem_addr_ff] <= mem_cmd_ff[3:0];
          cm_data[mem_addr_ff] <= mem_data_ff;
        end else if (mem_cmd_ff[6:3] == csd_pkg::OP_DATA) begin
          cm_data[mem_addr_ff] <= mem_data_ff;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Change address queue
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q_cnt = q_cnt_ff;
    if (clr) begin
      nxt_q_cnt = {3'h0, push}; // Entry pushed during clear survives
    end else if (push && !pop) begin
      nxt_q_cnt = q_cnt_ff + 4'h1;
    end else if (pop && !push) begin
      nxt_q_cnt = q_cnt_ff - 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q_cnt_ff <= 4'h0;
      q_rd_ff <= 4'h0;
      q_wr_ff <= 4'h0;
    end else if (ce) begin
      q_cnt_ff <= nxt_q_cnt;
      if (clr) begin
        q_rd_ff <= 4'h0;
        q_wr_ff <= push ? 4'h1 : 4'h0;
      end else begin
        if (pop) begin
          q_rd_ff <= (q_rd_ff == 4'h8) ? 4'h0 : q_rd_ff + 4'h1;
        end
        if (push) begin
          q_wr_ff <= (q_wr_ff == 4'h8) ? 4'h0 : q_wr_ff + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && push) begin
      queue[clr ? 4'h0 : q_wr_ff] <= {1'b1, push_addr[6:0]};
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin and downstream repeat
  // ----------------------------------------------------------------
  assign irq_pin_n = ~((q_cnt_ff != 4'h0) &
                       ~mask_ff[csd_pkg::B_SFI]);

  assign ds_a = {1'b0, ds_slot[6:1], 1'b0};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ds_data_ff <= 8'hff;
    end else if (ce) begin
      if (cm_code[ds_a] == csd_pkg::CODE_CI ||
          cm_code[ds_a] == csd_pkg::CODE_SIG6 ||
          cm_code[ds_a] == csd_pkg::CODE_SIG8) begin
        ds_data_ff <= cm_data[ds_a];
      end else begin
        ds_data_ff <= 8'hff;
      end
    end
  end
  assign ds_data = ds_data_ff;

endmodule : csd_top

// ===== tb/csd_chk.sv
// Checker: bus, change flag, stall and timer properties
`timescale 1ns/1ps
module csd_chk #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic up_valid,
  input wire logic up_ready,
  input wire logic timer_tick,
  input wire logic irq_pin_n
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic bus, rd, rdq, wrt;
  assign bus = hsel && htrans[1] && hready && ce;
  assign rd = bus && !hwrite;
  assign rdq = rd && haddr == {24'h0, csd_pkg::A_QUEUE};
  assign wrt = bus && hwrite && haddr == {24'h0, csd_pkg::A_TIMER};
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay)
    else $error("slave not zero-wait OKAY");
  property p_upper; rd |=> hrdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper)
    else $error("upper read bits not zero");
  property p_empty; rdq |=> hrdata[7] || hrdata[7:0] == 8'h00; endproperty
  a_empty: assert property (p_empty)
    else $error("invalid entry not zero");
  property p_rise; $rose(irq_pin_n) |-> $past(bus) || $past(bus, 2);
  endproperty
  a_rise: assert property (p_rise)
    else $error("flag cleared without access");
  property p_fall;
    $fell(irq_pin_n) |-> $past(up_valid && up_ready) || $past(bus, 2);
  endproperty
  a_fall: assert property (p_fall)
    else $error("pin fell without cause");
  property p_stall; !up_ready |-> up_valid; endproperty
  a_stall: assert property (p_stall)
    else $error("stall with no sample");
  // Holds only for TICK_CYCLES of 9 or more
  property p_tick; timer_tick |=> !timer_tick [*8]; endproperty
  a_tick: assert property (p_tick)
    else $error("tick period too short");
  property p_stop; wrt |=> ##1 !timer_tick [*8]; endproperty
  a_stop: assert property (p_stop)
    else $error("timer runs after setting write");
endmodule : csd_chk

bind csd_top csd_chk #(.TICK_CYCLES(TICK_CYCLES)) csd_chk_inst (
  .ref_clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .up_valid, .up_ready, .timer_tick,
  .irq_pin_n
);

// ===== tb/csd_sub_model.sv
// Subscriber-side model: frame pulses and upstream samples
`timescale 1ns/1ps
module csd_sub_model #(
  parameter int FRAME_CYC = 64
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic up_ready,
  output logic frame_sync,
  output logic up_valid,
  output logic [6:0] up_slot,
  output logic [7:0] up_value
);
  // ------
  // Frame pulse, shortened frame
  // ------
  int cnt = 0;
  initial begin
    frame_sync = 1'b0;
    up_valid = 1'b0;
    up_slot = 7'h0;
    up_value = 8'h0;
  end
  always @(posedge ref_clk) begin
    cnt <= (rst || cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
    frame_sync <= !rst && cnt == FRAME_CYC - 1;
  end
  // Ready judged at negedge so a pop at the edge cannot race the release
  task automatic send(input logic [6:0] s, input logic [7:0] v);
    logic ok;
    @(posedge ref_clk);
    up_valid <= 1'b1;
    up_slot <= s;
    up_value <= v;
    do begin
      @(negedge ref_clk);
      ok = up_ready;
      @(posedge ref_clk);
    end while (ok !== 1'b1);
    up_valid <= 1'b0;
    up_value <= ~v;
  endtask : send
endmodule : csd_sub_model

// ===== tb/csd_top_tb.sv
// Testbench: registers, queue, debounce, timer, downstream
`timescale 1ns/1ps
module csd_top_tb;
  logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [6:0] ds_slot = 7'h0, up_slot;
  logic [7:0] up_value, ds_data, r;
  logic hreadyout, hresp, frame_sync, up_valid, up_ready, timer_tick;
  logic irq_pin_n;
  int num_errors = 0, n_tests = 0;
  csd_top #(.TICK_CYCLES(10)) csd_top_inst (
    .ref_clk, .rst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .frame_sync, .up_valid, .up_slot, .up_value, .up_ready,
    .ds_slot, .ds_data, .timer_tick, .irq_pin_n
  );
  csd_sub_model csd_sub_model_inst (
    .ref_clk, .rst, .up_ready, .frame_sync, .up_valid, .up_slot,
    .up_value
  );
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // ------
  // Bus and compare tasks
  // ------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0);
    chk(r, e);
  endtask : rd
  task automatic pin(input logic e);
    @(negedge ref_clk);
    chk({7'h0, irq_pin_n}, {7'h0, e});
  endtask : pin
  task automatic sd(input logic [6:0] s, input logic [7:0] v);
    csd_sub_model_inst.send(s, v);
  endtask : sd
  // Memory command completes later; poll busy bit
  task automatic cm(input logic [7:0] a, input logic [7:0] d,
                    input logic [7:0] c);
    wr(csd_pkg::A_MEM_ADDR, a);
    wr(csd_pkg::A_MEM_DATA, d);
    wr(csd_pkg::A_MEM_CMD, c);
    do bus(1'b0, csd_pkg::A_STATUS, 8'h0); while (r[7] !== 1'b0);
  endtask : cm
  task automatic gap(input logic [7:0] e);
    int n = 0;
    @(negedge ref_clk);
    while (timer_tick !== 1'b1) @(negedge ref_clk);
    do begin
      @(negedge ref_clk);
      n++;
    end while (timer_tick !== 1'b1);
    chk(8'(n), e);
  endtask : gap
  // ------
  // Scenarios
  // ------
  task automatic t_regs;
    rd(csd_pkg::A_STATUS, 8'h05);
    rd(csd_pkg::A_STATUS, 8'h05);
    rd(csd_pkg::A_IRQ_SRC, 8'h00);
    rd(8'h40, 8'h00);
    rd(csd_pkg::A_QUEUE, 8'h00);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_ci;
    cm(8'h86, 8'h00, 8'h77);
    wr(csd_pkg::A_MODE, 8'h01);
    sd(7'h07, 8'h3c);
    pin(1'b0);
    rd(csd_pkg::A_IRQ_SRC, 8'h40);
    rd(csd_pkg::A_IRQ_SRC, 8'h40);
    rd(csd_pkg::A_QUEUE, 8'h86);
    rd(csd_pkg::A_QUEUE, 8'h00);
    rd(csd_pkg::A_IRQ_SRC, 8'h00);
    sd(7'h07, 8'h3c);
    pin(1'b1);
    wr(csd_pkg::A_IRQ_MASK, 8'h40);
    sd(7'h07, 8'h00);
    pin(1'b1);
    rd(csd_pkg::A_IRQ_SRC, 8'h40);
    wr(csd_pkg::A_CMD, 8'h10);
    repeat (2) @(posedge ref_clk);
    rd(csd_pkg::A_IRQ_SRC, 8'h00);
    rd(csd_pkg::A_QUEUE, 8'h00);
    wr(csd_pkg::A_IRQ_MASK, 8'h00);
    $display("t_ci done");
  endtask : t_ci
  task automatic t_full;
    for (int i = 0; i < 10; i++) cm(8'(8'ha0 + 2 * i), 8'h00, 8'h77);
    for (int i = 0; i < 9; i++) sd(7'(7'h21 + 2 * i), 8'h3c);
    fork
      sd(7'h33, 8'h3c);
      begin
        repeat (3) @(negedge ref_clk);
        chk({7'h0, up_ready}, 8'h00);
        for (int i = 0; i < 10; i++) begin
          rd(csd_pkg::A_QUEUE, 8'(8'ha0 + 2 * i));
        end
      end
    join
    rd(csd_pkg::A_QUEUE, 8'h00);
    $display("t_full done");
  endtask : t_full
  task automatic t_sig;
    logic [7:0] v[3] = '{8'hfc, 8'hf0, 8'hf0};
    cm(8'he0, 8'h00, 8'h7a);
    cm(8'he1, 8'h00, 8'h7a);
    wr(csd_pkg::A_TIMER, 8'h80);
    for (int i = 0; i < 3; i++) begin
      @(posedge frame_sync);
      sd(7'h61, v[i]);
      pin(i < 2);
    end
    rd(csd_pkg::A_QUEUE, 8'he1);
    cm(8'he1, 8'h00, 8'hc8);
    rd(csd_pkg::A_MEM_DATA, 8'hf0);
    $display("t_sig done");
  endtask : t_sig
  task automatic t_timer;
    wr(csd_pkg::A_TIMER, 8'h00);
    wr(csd_pkg::A_CMD, 8'h40);
    rd(csd_pkg::A_STATUS, 8'h0d);
    gap(8'd10);
    wr(csd_pkg::A_TIMER, 8'h01);
    rd(csd_pkg::A_STATUS, 8'h05);
    wr(csd_pkg::A_CMD, 8'h40);
    gap(8'd20);
    wr(csd_pkg::A_MODE, 8'h00);
    rd(csd_pkg::A_STATUS, 8'h05);
    $display("t_timer done");
  endtask : t_timer
  task automatic t_ds;
    cm(8'h0a, 8'h14, 8'h77);
    @(posedge ref_clk) ds_slot <= 7'h0b;
    repeat (2) @(negedge ref_clk);
    chk(ds_data, 8'h14);
    cm(8'h0a, 8'h28, 8'h48);
    repeat (2) @(negedge ref_clk);
    chk(ds_data, 8'h28);
    $display("t_ds done");
  endtask : t_ds
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_ci;
    t_full;
    t_sig;
    t_timer;
    t_ds;
    tally_and_finish;
  end
  // Tests need under a thousand cycles; allow a wide margin
  initial begin
    #500000;
    num_errors++;
    tally_and_finish;
  end
endmodule : csd_top_tb
